// ==== core/hop_sequencer.sv ====
// Receive channel hop sequencer: synthesizer word, frequency and hop table walk
`timescale 1ns/10ps
`default_nettype none
module hop_sequencer
  import hop_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  // Configuration
  input  wire hop_pkg::hop_synth_cfg_s synth_cfg,
  input  wire hop_pkg::hop_ctrl_s    hop_ctrl,
  input  wire logic [6:0]            crystal_load_trim,
  // Hop table write port
  input  wire logic                  table_write,
  input  wire logic [5:0]            table_addr,
  input  wire logic [7:0]            table_data,
  // Receive commands
  input  wire logic                  rx_start,
  input  wire logic                  rx_channel_given,
  input  wire logic [7:0]            rx_channel,
  input  wire logic                  rx_stop,
  input  wire logic                  manual_hop,
  input  wire logic [7:0]            manual_channel,
  input  wire logic [10:0]           manual_cal_count,
  // Modem status
  input  wire logic [7:0]            signal_strength,
  input  wire logic                  preamble_timeout,
  input  wire logic                  sync_timeout,
  // Outputs
  output logic [FW-1:0]              synth_word,
  output logic [31:0]                rf_frequency,
  output logic                       rf_frequency_valid,
  output logic [7:0]                 channel,
  output logic [5:0]                 hop_index,
  output logic                       rx_active,
  output logic                       synth_tuning,
  output logic                       channel_held,
  output logic                       hop_gpio,
  output logic                       level_above,
  output logic [6:0]                 trim_setting,
  output logic [10:0]                oscillator_calibration_count
);
  import hop_pkg::*;

  function automatic logic [4:0] band_divider(input hop_band_e band);
    case (band)
      HOP_BAND_142_175:  band_divider = DIV_BAND_160;
      HOP_BAND_284_350:  band_divider = DIV_BAND_320;
      HOP_BAND_350_420:  band_divider = DIV_BAND_385;
      HOP_BAND_420_525:  band_divider = DIV_BAND_470;
      HOP_BAND_850_1050: band_divider = DIV_BAND_950;
      default:           band_divider = DIV_BAND_160;
    endcase
  endfunction

  function automatic logic [FW-1:0] chan_word(input hop_synth_cfg_s cfg, input logic [7:0] ch);
    logic [FW-1:0] base;
    logic [23:0]   offs;
    base = FW'({cfg.integer_part, 19'h0_0000}) + FW'(cfg.fractional_part);
    offs = ch * {cfg.step_high, cfg.step_low};
    chan_word = base + FW'(offs);
  endfunction

  // Entry after idx, back to the first one after the last active entry
  function automatic logic [5:0] next_slot(input logic [5:0] idx, input logic [5:0] last);
    next_slot = (idx >= last) ? 6'h00 : idx + 6'h01;
  endfunction

  function automatic logic over_limit(input logic [7:0] level, input logic [7:0] limit);
    over_limit = level > limit;
  endfunction

  logic [7:0]       hop_table [TABLE_DEPTH];
  hop_state_e       state;
  logic [11:0]      turn_cnt;
  logic [6:0]       scan_cnt;
  logic [5:0]       scan_idx;
  logic             manual_tune;
  logic [6:0]       active_len;
  logic [5:0]       last_idx;
  logic             hop_allowed;
  logic             stay_now;
  logic             hop_now;
  logic             tune_start;
  logic [7:0]       tune_channel;
  logic [DIVD_W-1:0] div_shift;
  logic [31:0]      div_quot;
  logic [4:0]       div_rem;
  logic [5:0]       div_left;
  logic [4:0]       div_ratio;
  logic [PROD_W-1:0] prod;
  logic [5:0]       rem_trial;
  logic             div_fits;

  // Table length beyond the storage is clamped so the walk never leaves it
  assign active_len = (hop_ctrl.table_size > 7'(TABLE_DEPTH)) ? 7'(TABLE_DEPTH)
                    : hop_ctrl.table_size;
  assign last_idx   = (active_len == 7'h00) ? 6'h00 : 6'(active_len - 7'h01);
  assign hop_allowed = hop_ctrl.auto_enable && (active_len != 7'h00);
  // First met condition decides; timeouts are ignored without packet handling
  assign stay_now = hop_ctrl.level_enable
                  && over_limit(signal_strength, hop_ctrl.signal_level_limit);
  assign hop_now  = (hop_ctrl.level_enable && !stay_now)
                  || (!hop_ctrl.raw_mode && hop_ctrl.preamble_enable && preamble_timeout)
                  || (!hop_ctrl.raw_mode && hop_ctrl.sync_enable && sync_timeout);
  // Combinational table read lets a found entry tune in the same cycle
  assign tune_start = rx_start || manual_hop
                    || (state == HOP_SEARCH && hop_table[scan_idx] != SKIP_MARK);
  assign tune_channel = manual_hop ? manual_channel
                      : (rx_start ? (rx_channel_given ? rx_channel : channel)
                      : hop_table[scan_idx]);

  always_ff @(posedge core_clk) begin
    if (table_write) begin
      hop_table[table_addr] <= table_data;
    end
  end

  // Channel kept across starts when the argument is absent
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      channel    <= CHANNEL_RESET;
      synth_word <= '0;
    end else if (tune_start) begin
      channel    <= tune_channel;
      synth_word <= chan_word(synth_cfg, tune_channel);
    end
  end

  // Sequencer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state        <= HOP_IDLE;
      turn_cnt     <= '0;
      scan_cnt     <= '0;
      scan_idx     <= '0;
      hop_index    <= '0;
      hop_gpio     <= 1'b0;
    end else if (rx_stop) begin
      state <= HOP_IDLE;
    end else if (rx_start || manual_hop) begin
      // Host launches on the first usable entry, so the walk starts at zero
      hop_index <= '0;
      state     <= HOP_TUNE;
      turn_cnt  <= manual_hop ? MANUAL_TURN_CYC : AUTO_TURN_CYC;
    end else begin
      case (state)
        HOP_IDLE: begin
          state <= HOP_IDLE;
        end
        HOP_TUNE: begin
          if (turn_cnt <= 12'h001) begin
            state <= (hop_allowed && !manual_tune) ? HOP_LISTEN : HOP_STAY;
          end
          turn_cnt <= turn_cnt - 12'h001;
        end
        HOP_LISTEN: begin
          if (!hop_allowed) begin
            state <= HOP_STAY;
          end else if (stay_now) begin
            state <= HOP_STAY;
          end else if (hop_now) begin
            state        <= HOP_SEARCH;
            scan_cnt     <= '0;
            scan_idx     <= next_slot(hop_index, last_idx);
          end
        end
        HOP_SEARCH: begin
          // Search cost is at most one cycle per entry, well inside the turnaround
          if (hop_table[scan_idx] != SKIP_MARK) begin
            hop_index <= scan_idx;
            state     <= HOP_TUNE;
            // Search cycles, this one included, come out of the turnaround budget
            turn_cnt  <= AUTO_TURN_CYC - 12'(scan_cnt) - 12'h001;
            if (hop_ctrl.gpio_toggle_enable) begin
              hop_gpio <= ~hop_gpio;
            end
          end else if (scan_cnt >= active_len - 7'h01) begin
            state <= HOP_STAY;
          end else begin
            scan_cnt     <= scan_cnt + 7'h01;
            scan_idx     <= next_slot(scan_idx, last_idx);
          end
          // A live last entry already toggled on its hop, so only skips toggle here
          if (hop_ctrl.gpio_toggle_enable && scan_idx >= last_idx
              && hop_table[scan_idx] == SKIP_MARK) begin
            hop_gpio <= ~hop_gpio;
          end
        end
        HOP_STAY: begin
          state <= HOP_STAY;
        end
        default: begin
          state <= HOP_IDLE;
        end
      endcase
    end
  end

  // Manual hops settle on their channel; a new start resumes the walk
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      manual_tune <= 1'b0;
    end else if (rx_stop || rx_start || manual_hop) begin
      manual_tune <= manual_hop && !rx_stop;
    end
  end

  // Status flags
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_active    <= 1'b0;
      synth_tuning <= 1'b0;
      channel_held <= 1'b0;
      level_above  <= 1'b0;
    end else begin
      rx_active    <= (state != HOP_IDLE) && !rx_stop;
      synth_tuning <= (state == HOP_TUNE) || (state == HOP_SEARCH);
      // Held drops with a stop so it never shows outside receive
      channel_held <= (state == HOP_STAY) && !rx_stop;
      level_above  <= over_limit(signal_strength, hop_ctrl.signal_level_limit);
    end
  end

  // Trim and calibration count held for the analog side
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      trim_setting                 <= '0;
      oscillator_calibration_count <= '0;
    end else begin
      trim_setting <= (crystal_load_trim > TRIM_MAX) ? TRIM_MAX : crystal_load_trim;
      if (manual_hop) begin
        oscillator_calibration_count <= manual_cal_count;
      end
    end
  end

  // Frequency in Hz: word times 2*ref over 2^19, then a serial divide by the ratio
  // Serial divide trades one result per DIV_STEPS + 1 cycles (a load cycle, then 35 steps) for a tiny datapath
  assign prod      = PROD_W'(synth_word) * PROD_W'(synth_cfg.reference_frequency);
  assign rem_trial = {div_rem, div_shift[DIVD_W-1]};
  assign div_fits  = rem_trial >= {1'b0, div_ratio};

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_shift          <= '0;
      div_quot           <= '0;
      div_rem            <= '0;
      div_left           <= '0;
      div_ratio          <= DIV_BAND_160;
      rf_frequency       <= '0;
      rf_frequency_valid <= 1'b0;
    end else if (tune_start) begin
      div_left           <= 6'h00;
      rf_frequency_valid <= 1'b0;
    end else if (div_left == 6'h00 && !rf_frequency_valid && synth_word != '0) begin
      div_shift <= DIVD_W'(prod >> (FRAC_SHIFT - 1));
      div_ratio <= band_divider(synth_cfg.band);
      div_rem   <= '0;
      div_quot  <= '0;
      div_left  <= DIV_STEPS;
    end else if (div_left != 6'h00) begin
      div_shift <= div_shift << 1;
      if (div_fits) begin
        div_rem  <= 5'(rem_trial - {1'b0, div_ratio});
        div_quot <= {div_quot[30:0], 1'b1};
      end else begin
        div_rem  <= rem_trial[4:0];
        div_quot <= {div_quot[30:0], 1'b0};
      end
      div_left <= div_left - 6'h01;
      if (div_left == 6'h01) begin
        rf_frequency       <= div_fits ? {div_quot[30:0], 1'b1}
                            : {div_quot[30:0], 1'b0};
        rf_frequency_valid <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== core/hop_pkg.sv ====
// Package of constants, types and structs for the receive channel hop sequencer
package hop_pkg;
  localparam int          CLK_HZ          = 25_000_000;
  localparam int          AUTO_TURN_NS    = 115_000;
  localparam int          MANUAL_TURN_NS  = 75_000;
  // Longest times round down to whole cycles
  localparam logic [11:0] AUTO_TURN_CYC   = 12'(AUTO_TURN_NS / (1_000_000_000 / CLK_HZ));
  localparam logic [11:0] MANUAL_TURN_CYC = 12'(MANUAL_TURN_NS / (1_000_000_000 / CLK_HZ));
  localparam int          FRAC_SHIFT      = 19;
  localparam int          FW              = 28;
  localparam int          REF_W           = 25;
  localparam int          PROD_W          = FW + REF_W;
  localparam int          DIVD_W          = PROD_W - FRAC_SHIFT + 1;
  localparam logic [5:0]  DIV_STEPS       = 6'(DIVD_W);
  localparam int          TABLE_DEPTH     = 64;
  localparam logic [7:0]  SKIP_MARK       = 8'hFF;
  localparam logic [7:0]  CHANNEL_RESET   = 8'h00;
  localparam logic [6:0]  TRIM_MAX        = 7'h7F;
  localparam logic [4:0]  DIV_BAND_160    = 5'h18;
  localparam logic [4:0]  DIV_BAND_320    = 5'h0C;
  localparam logic [4:0]  DIV_BAND_385    = 5'h0A;
  localparam logic [4:0]  DIV_BAND_470    = 5'h08;
  localparam logic [4:0]  DIV_BAND_950    = 5'h04;

  typedef enum logic [2:0] {
    HOP_BAND_142_175  = 3'h0,
    HOP_BAND_284_350  = 3'h1,
    HOP_BAND_350_420  = 3'h2,
    HOP_BAND_420_525  = 3'h3,
    HOP_BAND_850_1050 = 3'h4
  } hop_band_e;

  typedef enum logic [4:0] {
    HOP_IDLE   = 5'b00001,
    HOP_LISTEN = 5'b00010,
    HOP_SEARCH = 5'b00100,
    HOP_TUNE   = 5'b01000,
    HOP_STAY   = 5'b10000
  } hop_state_e;

  typedef struct packed {
    logic [7:0]       integer_part;
    logic [19:0]      fractional_part;
    logic [7:0]       step_high;
    logic [7:0]       step_low;
    logic [REF_W-1:0] reference_frequency;
    hop_band_e        band;
  } hop_synth_cfg_s;

  typedef struct packed {
    logic       auto_enable;
    logic       level_enable;
    logic       preamble_enable;
    logic       sync_enable;
    logic       raw_mode;
    logic       gpio_toggle_enable;
    logic [6:0] table_size;
    logic [7:0] signal_level_limit;
  } hop_ctrl_s;
endpackage

// ==== test/hop_host_model.sv ====
// Host side model: synthesizer settings, trim and hop table loading
`timescale 1ns/10ps
`default_nettype none
module hop_host_model
  import hop_pkg::*;
(
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                nrst,
  // Bench requests
  input  wire logic                load,
  input  wire logic [63:0][7:0]    image,
  input  wire hop_pkg::hop_band_e  band,
  input  wire logic [REF_W-1:0]    ref_hz,
  input  wire logic                ext_ref,
  input  wire logic [6:0]          trim,
  // Toward the sequencer
  output var hop_pkg::hop_synth_cfg_s synth_cfg,
  output logic [6:0]               crystal_load_trim,
  output logic                     table_write,
  output logic [5:0]               table_addr,
  output logic [7:0]               table_data,
  output logic                     busy
);
  import hop_pkg::*;
  logic [5:0] n;
  // Fraction kept inside one to two, step given as both halves
  assign synth_cfg = '{8'h1E, 20'hA3D71, 8'h04, 8'h56, ref_hz, band};
  assign crystal_load_trim = ext_ref ? 7'h00 : trim;
  assign table_write = busy;
  assign table_addr = n;
  assign table_data = image[n];
  // Whole table rewritten each load, so stale entries never linger
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
      n <= 6'h00;
    end else if (load) begin
      busy <= 1'b1;
      n <= 6'h00;
    end else if (busy) begin
      busy <= (n != 6'h3F);
      n <= n + 6'h01;
    end
  end
endmodule
`default_nettype wire

// ==== test/hop_monitor.sv ====
// Port checker for the hop sequencer
`timescale 1ns/10ps
`default_nettype none
module hop_monitor
  import hop_pkg::*;
(
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    nrst,
  // Inputs watched
  input  wire hop_pkg::hop_synth_cfg_s synth_cfg,
  input  wire hop_pkg::hop_ctrl_s      hop_ctrl,
  input  wire logic [6:0]              crystal_load_trim,
  input  wire logic                    rx_start,
  input  wire logic                    rx_channel_given,
  input  wire logic [7:0]              rx_channel,
  input  wire logic                    rx_stop,
  input  wire logic                    manual_hop,
  input  wire logic [7:0]              manual_channel,
  input  wire logic [10:0]             manual_cal_count,
  input  wire logic [7:0]              signal_strength,
  // Outputs watched
  input  wire logic [FW-1:0]           synth_word,
  input  wire logic [7:0]              channel,
  input  wire logic                    synth_tuning,
  input  wire logic                    channel_held,
  input  wire logic                    rx_active,
  input  wire logic                    hop_gpio,
  input  wire logic                    level_above,
  input  wire logic [6:0]              trim_setting,
  input  wire logic [10:0]             oscillator_calibration_count
);
  import hop_pkg::*;
  localparam int TURN = AUTO_TURN_CYC;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [11:0]   tune_cnt;
  logic [FW-1:0] exp_word;
  logic          plain;
  logic          cmd_d;
  assign plain = !rx_stop && !manual_hop;
  assign exp_word = FW'({synth_cfg.integer_part, 19'h0}) + FW'(synth_cfg.fractional_part)
    + FW'(rx_channel) * FW'({synth_cfg.step_high, synth_cfg.step_low});
  // Restarted tunes clear the count, so a restart is not a long tune
  // Tuning flag lags a command by one cycle, so that cycle is cleared too
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tune_cnt <= 12'h000;
      cmd_d    <= 1'b0;
    end else begin
      cmd_d <= rx_start || manual_hop || rx_stop;
      if (rx_start || manual_hop || rx_stop || cmd_d || !synth_tuning) begin
        tune_cnt <= 12'h000;
      end else begin
        tune_cnt <= tune_cnt + 12'h001;
      end
    end
  end
  level_flag_a:
    assert property ($past(nrst) |-> level_above == $past(signal_strength > hop_ctrl.signal_level_limit))
    else $error("level flag wrong");
  trim_copy_a:
    assert property ($past(nrst) |-> trim_setting == $past(crystal_load_trim))
    else $error("trim setting wrong");
  start_word_a:
    assert property (rx_start && rx_channel_given && plain |=>
      channel == $past(rx_channel) && synth_word == $past(exp_word)) else $error("start word wrong");
  start_keep_a:
    assert property (rx_start && !rx_channel_given && plain |=> $stable(channel))
    else $error("channel not kept");
  manual_load_a:
    assert property (manual_hop && !rx_stop |=> channel == $past(manual_channel)
      && oscillator_calibration_count == $past(manual_cal_count)) else $error("manual hop wrong");
  tune_length_a:
    assert property (tune_cnt <= 12'(TURN)) else $error("tune too long");
  gpio_quiet_a:
    assert property (!hop_ctrl.gpio_toggle_enable |=> $stable(hop_gpio)) else $error("gpio moved");
  held_active_a:
    assert property (channel_held |-> rx_active && !synth_tuning) else $error("held state wrong");
  cover property (channel_held && hop_ctrl.auto_enable);
  cover property ($changed(hop_gpio));
  cover property (manual_hop);
endmodule
bind hop_sequencer hop_monitor i_mon (.core_clk, .nrst, .synth_cfg, .hop_ctrl, .crystal_load_trim,
  .rx_start, .rx_channel_given, .rx_channel, .rx_stop, .manual_hop, .manual_channel,
  .manual_cal_count, .signal_strength, .synth_word, .channel, .synth_tuning, .channel_held,
  .rx_active, .hop_gpio, .level_above, .trim_setting, .oscillator_calibration_count);
`default_nettype wire

// ==== test/rx_channel_hop_sequencer_bench.sv ====
// Self-checking bench for the receive channel hop sequencer
`timescale 1ns/10ps
`default_nettype none
module rx_channel_hop_sequencer_bench;
  import hop_pkg::*;
  logic             core_clk, nrst, load, ext_ref, table_write, busy, gbit;
  logic             rx_start, rx_channel_given, rx_stop, manual_hop;
  logic             preamble_timeout, sync_timeout, rf_frequency_valid, rx_active;
  logic             synth_tuning, channel_held, hop_gpio, level_above;
  logic [7:0]       rx_channel, manual_channel, signal_strength, table_data, last_ch, channel;
  logic [63:0][7:0] image;
  logic [6:0]       trim, crystal_load_trim, trim_setting;
  logic [5:0]       table_addr, hop_index;
  logic [10:0]      manual_cal_count, oscillator_calibration_count;
  logic [REF_W-1:0] ref_hz;
  logic [FW-1:0]    synth_word;
  logic [31:0]      rf_frequency;
  hop_band_e        band;
  hop_synth_cfg_s   synth_cfg;
  hop_ctrl_s        hop_ctrl;
  logic [4:0]       divs [5] = '{DIV_BAND_160, DIV_BAND_320, DIV_BAND_385, DIV_BAND_470, DIV_BAND_950};
  int               seed = 32'h96437004;
  int               miscompares, samples_checked, k, idx;
  hop_host_model i_host (.core_clk, .nrst, .load, .image, .band, .ref_hz, .ext_ref, .trim,
    .synth_cfg, .crystal_load_trim, .table_write, .table_addr, .table_data, .busy);
  hop_sequencer i_dut (.core_clk, .nrst, .synth_cfg, .hop_ctrl, .crystal_load_trim, .table_write,
    .table_addr, .table_data, .rx_start, .rx_channel_given, .rx_channel, .rx_stop, .manual_hop,
    .manual_channel, .manual_cal_count, .signal_strength, .preamble_timeout, .sync_timeout,
    .synth_word, .rf_frequency, .rf_frequency_valid, .channel, .hop_index, .rx_active,
    .synth_tuning, .channel_held, .hop_gpio, .level_above, .trim_setting,
    .oscillator_calibration_count);
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Bounded wait: 0 held, 1 result valid, 2 channel moved, 3 tune over
  task automatic wait_for(input int sel);
    for (k = 0; k < 3200; k++) begin
      if (sel == 0 && channel_held === 1'b1) break;
      if (sel == 1 && rf_frequency_valid === 1'b1) break;
      if (sel == 2 && channel !== last_ch) break;
      if (sel == 3 && synth_tuning === 1'b0) break;
      tick(1);
    end
    if (k == 3200) chk(32'h0, 32'h1);
  endtask
  task automatic start(input logic given, input logic [7:0] ch);
    rx_start = 1'b1;
    rx_channel_given = given;
    rx_channel = ch;
    tick(1);
    rx_start = 1'b0;
    rx_channel = ~ch;
    tick(2);
  endtask
  task automatic load_table;
    load = 1'b1;
    tick(1);
    load = 1'b0;
    tick(66);
  endtask
  function automatic logic [31:0] exp_freq(input logic [7:0] ch, input logic [4:0] div);
    logic [63:0] w;
    w = 64'({synth_cfg.integer_part, 19'h0}) + 64'(synth_cfg.fractional_part)
      + 64'(ch) * 64'({synth_cfg.step_high, synth_cfg.step_low});
    return 32'(((w * 64'(synth_cfg.reference_frequency) * 64'h2) >> 19) / 64'(div));
  endfunction
  function automatic int next_idx(input int i);
    int j;
    j = i;
    do j = (j + 1) % 6; while (image[j] == SKIP_MARK && j != i);
    return j;
  endfunction
  task automatic print_verdict;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #4_000_000;
    chk(32'h0, 32'h1);
    print_verdict;
  end
  initial begin
    {nrst, load, ext_ref, rx_start, rx_channel_given, rx_stop, manual_hop} = '0;
    {preamble_timeout, sync_timeout, rx_channel, manual_channel, manual_cal_count} = '0;
    image = '1;
    trim = 7'($random(seed));
    ref_hz = 25'h17D7840 + 25'({$random(seed)} % 32'h6ACFC0);
    band = HOP_BAND_142_175;
    hop_ctrl = '0;
    hop_ctrl.signal_level_limit = 8'h80;
    signal_strength = 8'h10;
    tick(6);
    nrst = 1'b1;
    tick(2);
    chk(32'(channel), 32'(CHANNEL_RESET));
    chk(32'(trim_setting), 32'(trim));
    // Every band, with and without the channel argument
    for (int b = 0; b < 5; b++) begin
      band = hop_band_e'(b);
      for (int g = 1; g >= 0; g--) begin
        if (g == 1) idx = {$random(seed)} & 32'h7;
        start(g[0], 8'(idx + 3 * (1 - g)));
        wait_for(1);
        chk(rf_frequency, exp_freq(8'(idx), divs[b]));
        wait_for(0);
      end
    end
    ext_ref = 1'b1;
    tick(2);
    chk(32'(trim_setting), 32'h0);
    // Walk with skips and wrap, level below limit
    image[5:0] = {8'h0C, 8'h09, SKIP_MARK, 8'h07, SKIP_MARK, 8'h03};
    load_table;
    hop_ctrl.auto_enable = 1'b1;
    hop_ctrl.level_enable = 1'b1;
    hop_ctrl.gpio_toggle_enable = 1'b1;
    hop_ctrl.table_size = 7'h06;
    idx = 0;
    start(1'b1, image[0]);
    chk(32'(hop_index), 32'h0);
    for (int h = 0; h < 5; h++) begin
      last_ch = channel;
      gbit = hop_gpio;
      signal_strength = 8'({$random(seed)} & 32'h7F);
      idx = next_idx(idx);
      wait_for(2);
      chk(32'(channel), 32'(image[idx]));
      chk(32'(hop_index), 32'(idx));
      chk(32'(hop_gpio), 32'(!gbit));
    end
    signal_strength = 8'hC0;
    wait_for(0);
    chk(32'(channel), 32'(image[idx]));
    // Only the preamble condition enabled
    hop_ctrl.level_enable = 1'b0;
    hop_ctrl.preamble_enable = 1'b1;
    signal_strength = 8'h10;
    start(1'b1, image[0]);
    wait_for(3);
    tick(20);
    chk(32'(channel), 32'(image[0]));
    last_ch = channel;
    preamble_timeout = 1'b1;
    tick(1);
    preamble_timeout = 1'b0;
    wait_for(2);
    chk(32'(channel), 32'(image[2]));
    // Raw mode ignores the timeouts
    hop_ctrl.raw_mode = 1'b1;
    hop_ctrl.sync_enable = 1'b1;
    wait_for(3);
    sync_timeout = 1'b1;
    tick(1);
    sync_timeout = 1'b0;
    tick(40);
    chk(32'(channel), 32'(image[2]));
    // Sync timeout with packet handling moves on
    hop_ctrl.raw_mode = 1'b0;
    last_ch = channel;
    sync_timeout = 1'b1;
    tick(1);
    sync_timeout = 1'b0;
    wait_for(2);
    chk(32'(channel), 32'(image[4]));
    rx_stop = 1'b1;
    tick(1);
    rx_stop = 1'b0;
    tick(2);
    chk(32'(rx_active), 32'h0);
    // Table of nothing but skip markers
    image = '1;
    load_table;
    hop_ctrl.raw_mode = 1'b0;
    hop_ctrl.level_enable = 1'b1;
    start(1'b1, 8'h21);
    wait_for(0);
    chk(32'(channel), 32'h21);
    manual_channel = 8'($random(seed));
    manual_cal_count = 11'($random(seed));
    manual_hop = 1'b1;
    tick(1);
    manual_hop = 1'b0;
    tick(3);
    wait_for(0);
    chk(32'(k < 32'(MANUAL_TURN_CYC) + 32'h8), 32'h1);
    chk(32'(oscillator_calibration_count), 32'(manual_cal_count));
    print_verdict;
  end
endmodule
`default_nettype wire
